// ### vtt_top.sv
// Purpose: voltage and clock transition timing with an AXI4-Lite register port
// Assumes: lp_enter, lp_exit, clk_ramped and vid_req come from aclk logic;
//          link_stop_n is a pin; perf_state_enable is stable around reset
// Notes:   a numerically smaller voltage identifier means a higher voltage
//
// Functional notes
// [R01] supply core and northbridge ids; alt on lowpower
// [R02] exit: restore id, settle, then resume
// [R03] ramp clocks down before issuing alternate id
// [R04] link delay field, reset zero, microsecond units
// [R05] hold link control until delay elapsed; the code holds only with tri_en set and rxls above one
// [R06] link receiver enabled one microsecond after stop
// [R07] alternate settle field, reset all ones
// [R08] voltage settle before frequency change, reset ones
// [R09] settle codes decode to 10..500 microseconds
// [R10] no wait after a lowering command
// [R11] northbridge changes only on differing write
// [R12] max performance index from highest enable
// [R13] alternate id drives core during lowpower
// [R14] software keeps alternate id within limits
// [R15] microsecond counter holds next step until expiry
`include "vtt_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module vtt_top
#(
  parameter logic [6:0] ALT_VID_RST = 7'h40,
  parameter logic [6:0] NB_VID_RST  = 7'h40,
  parameter logic [6:0] OP_VID_RST  = 7'h30
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output var  logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  input  wire logic        lp_enter,
  input  wire logic        lp_exit,
  input  wire logic        clk_ramped,
  input  wire logic        vid_req,
  input  wire logic [6:0]  vid_req_value,
  input  wire logic [7:0]  perf_state_enable,
  input  wire logic        link_stop_n,
  output var  logic [6:0]  core_voltage_id,
  output var  logic [6:0]  northbridge_voltage_id,
  output var  logic        core_cmd_stb,
  output var  logic        nb_cmd_stb,
  output var  logic        clk_ramp_req,
  output var  logic        exec_resume,
  output var  logic        fid_change_go,
  output var  logic        link_rx_en,
  output var  logic        link_control_signal
);
  import vtt_pkg::*;

  localparam int unsigned CYC_PER_US = `VTT_US_NS / `VTT_CLK_NS;
  localparam logic [7:0]  PRE_LOAD   = 8'(CYC_PER_US - 1);

  vtt_state_reg_t s_r;
  vtt_state_reg_t s_nxt;

  // ==========================================================================
  // helpers
  // [R09] settle code decode
  function automatic logic [9:0] settle_us(input logic [2:0] code);
    case (code)
      3'h0:    settle_us = `VTT_SETTLE_US0;
      3'h1:    settle_us = `VTT_SETTLE_US1;
      3'h2:    settle_us = `VTT_SETTLE_US2;
      3'h3:    settle_us = `VTT_SETTLE_US3;
      3'h4:    settle_us = `VTT_SETTLE_US4;
      3'h5:    settle_us = `VTT_SETTLE_US5;
      3'h6:    settle_us = `VTT_SETTLE_US6;
      default: settle_us = `VTT_SETTLE_US7;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        merge[i*8 +: 8] = dat[i*8 +: 8];
    end
  endfunction

  // [R12] highest enabled performance state, zero if none
  function automatic logic [2:0] top_ps(input logic [7:0] en);
    top_ps = 3'h0;
    for (int i = 0; i < 8; i++)
    begin
      if (en[i])
        top_ps = 3'(i);
    end
  endfunction

  // ==========================================================================
  // next state
  always_comb
  begin
    logic [31:0] img1;
    logic [31:0] img2;
    logic [31:0] img3;
    logic [31:0] wm;
    logic        gated;
    img1  = 32'h0;
    img2  = 32'h0;
    img3  = 32'h0;
    wm    = 32'h0;
    gated = 1'b0;
    s_nxt = s_r;
    img1[`VTT_LNK_DLY_MSB:`VTT_LNK_DLY_LSB] = s_r.lnk_dly;
    img1[`VTT_ALT_SET_MSB:`VTT_ALT_SET_LSB] = s_r.alt_set;
    img1[`VTT_VS_SET_MSB:`VTT_VS_SET_LSB]   = s_r.vs_set;
    img2[`VTT_NB_VID_MSB:`VTT_NB_VID_LSB]   = s_r.nb_vid;
    img2[`VTT_MAX_PS_MSB:`VTT_MAX_PS_LSB]   = s_r.max_ps;
    img2[`VTT_ALT_VID_MSB:`VTT_ALT_VID_LSB] = s_r.alt_vid;
    img3[`VTT_SEQ_ALT_EN]                   = s_r.alt_en;
    img3[`VTT_SEQ_TRI_EN]                   = s_r.tri_en;
    img3[`VTT_SEQ_RXLS_MSB:`VTT_SEQ_RXLS_LSB] = s_r.rxls;
    img3[`VTT_SEQ_ST_MSB:`VTT_SEQ_ST_LSB]   = s_r.state;
    img3[`VTT_SEQ_VID_MSB:`VTT_SEQ_VID_LSB] = s_r.core_vid;
    s_nxt.core_cmd = 1'b0;
    s_nxt.nb_cmd   = 1'b0;
    s_nxt.resume   = 1'b0;
    s_nxt.fid_go   = 1'b0;

    // bus write: address and data taken in either order
    if (s_axi_awvalid && s_r.awready)
    begin
      s_nxt.aw_held = 1'b1;
      s_nxt.awaddr  = s_axi_awaddr;
      s_nxt.awready = 1'b0;
    end
    if (s_axi_wvalid && s_r.wready)
    begin
      s_nxt.w_held = 1'b1;
      s_nxt.wdata  = s_axi_wdata;
      s_nxt.wstrb  = s_axi_wstrb;
      s_nxt.wready = 1'b0;
    end
    if (s_r.aw_held && s_r.w_held)
    begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = `VTT_RESP_OKAY;
      case (s_r.awaddr)
        `VTT_OFS_CTL1:
        begin
          wm = merge(img1, s_r.wdata, s_r.wstrb);
          // [R04] [R07] [R08] writable timing fields
          s_nxt.lnk_dly = wm[`VTT_LNK_DLY_MSB:`VTT_LNK_DLY_LSB];
          s_nxt.alt_set = wm[`VTT_ALT_SET_MSB:`VTT_ALT_SET_LSB];
          s_nxt.vs_set  = wm[`VTT_VS_SET_MSB:`VTT_VS_SET_LSB];
        end
        `VTT_OFS_CTL2:
        begin
          wm = merge(img2, s_r.wdata, s_r.wstrb);
          s_nxt.max_ps  = wm[`VTT_MAX_PS_MSB:`VTT_MAX_PS_LSB];
          s_nxt.alt_vid = wm[`VTT_ALT_VID_MSB:`VTT_ALT_VID_LSB];
          // [R11] command only on a changed value
          if (wm[`VTT_NB_VID_MSB:`VTT_NB_VID_LSB] != s_r.nb_vid)
          begin
            s_nxt.nb_vid = wm[`VTT_NB_VID_MSB:`VTT_NB_VID_LSB];
            s_nxt.nb_cmd = 1'b1;
          end
        end
        `VTT_OFS_SEQ:
        begin
          wm = merge(img3, s_r.wdata, s_r.wstrb);
          s_nxt.alt_en = wm[`VTT_SEQ_ALT_EN];
          s_nxt.tri_en = wm[`VTT_SEQ_TRI_EN];
          s_nxt.rxls   = wm[`VTT_SEQ_RXLS_MSB:`VTT_SEQ_RXLS_LSB];
        end
        default: s_nxt.bresp = `VTT_RESP_SLVERR;
      endcase
    end
    if (s_r.bvalid && s_axi_bready)
    begin
      s_nxt.bvalid  = 1'b0;
      s_nxt.awready = 1'b1;
      s_nxt.wready  = 1'b1;
    end

    // bus read
    if (s_axi_arvalid && s_r.arready)
    begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid  = 1'b1;
      s_nxt.rresp   = `VTT_RESP_OKAY;
      case (s_axi_araddr)
        `VTT_OFS_CTL1: s_nxt.rdata = img1;
        `VTT_OFS_CTL2: s_nxt.rdata = img2;
        `VTT_OFS_SEQ:  s_nxt.rdata = img3;
        default:
        begin
          s_nxt.rdata = 32'h0;
          s_nxt.rresp = `VTT_RESP_SLVERR;
        end
      endcase
    end
    if (s_r.rvalid && s_axi_rready)
    begin
      s_nxt.rvalid  = 1'b0;
      s_nxt.arready = 1'b1;
    end

    // [R15] microsecond settle counter
    if (s_r.set_pre == 8'h0)
    begin
      s_nxt.set_pre = PRE_LOAD;
      if (s_r.set_us != 10'h0)
        s_nxt.set_us = s_r.set_us - 10'h1;
    end
    else
      s_nxt.set_pre = s_r.set_pre - 8'h1;
    gated = (s_r.set_us == 10'h1) && (s_r.set_pre == 8'h0);

    // core voltage sequencer
    case (s_r.state)
      ST_IDLE:
      begin
        if (lp_enter && s_r.alt_en)
        begin
          // [R03] clocks down first
          s_nxt.ramp_req = 1'b1;
          s_nxt.state    = ST_RAMP;
        end
        else if (lp_enter)
        begin
          s_nxt.alt_used = 1'b0;
          s_nxt.state    = ST_LOWPWR;
        end
        else if (vid_req)
        begin
          s_nxt.op_vid   = vid_req_value;
          s_nxt.core_vid = vid_req_value;
          s_nxt.core_cmd = 1'b1;
          // [R08] raising command waits before frequency change
          if (vid_req_value < s_r.core_vid)
          begin
            s_nxt.set_us  = settle_us(s_r.vs_set);
            s_nxt.set_pre = PRE_LOAD;
            s_nxt.state   = ST_VSSET;
          end
          else
            // [R10] lowering command, no wait
            s_nxt.fid_go = 1'b1;
        end
      end
      ST_RAMP:
      begin
        if (clk_ramped)
        begin
          // [R01] [R13] alternate id onto the core plane
          s_nxt.core_vid = s_r.alt_vid;
          s_nxt.core_cmd = 1'b1;
          s_nxt.alt_used = 1'b1;
          s_nxt.state    = ST_LOWPWR;
        end
      end
      ST_LOWPWR:
      begin
        if (lp_exit && s_r.alt_used)
        begin
          // [R02] restore operating id, then settle
          s_nxt.core_vid = s_r.op_vid;
          s_nxt.core_cmd = 1'b1;
          s_nxt.set_us   = settle_us(s_r.alt_set);
          s_nxt.set_pre  = PRE_LOAD;
          s_nxt.state    = ST_ALTSET;
        end
        else if (lp_exit)
        begin
          s_nxt.resume = 1'b1;
          s_nxt.state  = ST_IDLE;
        end
      end
      ST_ALTSET:
      begin
        // [R02] [R15] resume only after the settle time
        if (gated)
        begin
          s_nxt.ramp_req = 1'b0;
          s_nxt.resume   = 1'b1;
          s_nxt.state    = ST_IDLE;
        end
      end
      ST_VSSET:
      begin
        if (gated)
        begin
          s_nxt.fid_go = 1'b1;
          s_nxt.state  = ST_IDLE;
        end
      end
      default: s_nxt.state = ST_IDLE;
    endcase

    // link start timing; link_stop_n passes two flops first
    s_nxt.ls_s1   = link_stop_n;
    s_nxt.ls_s2   = s_r.ls_s1;
    s_nxt.ls_prev = s_r.ls_s2;
    if (!s_r.ls_s2)
    begin
      s_nxt.lnk_run = 1'b0;
      s_nxt.rx_en   = 1'b0;
      s_nxt.ctl_en  = 1'b0;
    end
    else if (!s_r.ls_prev)
    begin
      s_nxt.lnk_run = 1'b1;
      s_nxt.lnk_us  = 5'h0;
      s_nxt.lnk_pre = PRE_LOAD;
    end
    else if (s_r.lnk_run)
    begin
      if (s_r.lnk_pre == 8'h0)
      begin
        s_nxt.lnk_pre = PRE_LOAD;
        s_nxt.lnk_us  = s_r.lnk_us + 5'h1;
      end
      else
        s_nxt.lnk_pre = s_r.lnk_pre - 8'h1;
      // [R06] receiver one microsecond after release
      if (s_r.lnk_us >= 5'(`VTT_RX_EN_US))
        s_nxt.rx_en = 1'b1;
      // [R04] [R05] hold control for the programmed delay when tri_en is set and rxls is above one
      if (!(s_r.tri_en && s_r.rxls > `VTT_RXLS_ONE) || (s_r.lnk_us >= {1'b0, s_r.lnk_dly}))
        s_nxt.ctl_en = 1'b1;
      if (s_r.rx_en && s_r.ctl_en)
        s_nxt.lnk_run = 1'b0;
    end

    if (!aresetn)
    begin
      s_nxt          = '0;
      s_nxt.awready  = 1'b1;
      s_nxt.wready   = 1'b1;
      s_nxt.arready  = 1'b1;
      s_nxt.lnk_dly  = `VTT_LNK_DLY_RST;
      s_nxt.alt_set  = `VTT_ALT_SET_RST;
      s_nxt.vs_set   = `VTT_VS_SET_RST;
      s_nxt.nb_vid   = NB_VID_RST;
      s_nxt.alt_vid  = ALT_VID_RST;
      s_nxt.core_vid = OP_VID_RST;
      s_nxt.op_vid   = OP_VID_RST;
      s_nxt.state    = ST_IDLE;
      s_nxt.set_pre  = PRE_LOAD;
      // [R12] strap caught on the clocked reset
      s_nxt.max_ps   = top_ps(perf_state_enable);
    end
  end

  always_ff @(posedge aclk)
  begin
    s_r <= s_nxt;
  end

  // ==========================================================================
  // outputs
  assign s_axi_awready          = s_r.awready;
  assign s_axi_wready           = s_r.wready;
  assign s_axi_bvalid           = s_r.bvalid;
  assign s_axi_bresp            = s_r.bresp;
  assign s_axi_arready          = s_r.arready;
  assign s_axi_rvalid           = s_r.rvalid;
  assign s_axi_rdata            = s_r.rdata;
  assign s_axi_rresp            = s_r.rresp;
  assign core_voltage_id        = s_r.core_vid;
  assign northbridge_voltage_id = s_r.nb_vid;
  assign core_cmd_stb           = s_r.core_cmd;
  assign nb_cmd_stb             = s_r.nb_cmd;
  assign clk_ramp_req           = s_r.ramp_req;
  assign exec_resume            = s_r.resume;
  assign fid_change_go          = s_r.fid_go;
  assign link_rx_en             = s_r.rx_en;
  assign link_control_signal    = s_r.ctl_en;

  // ==========================================================================
  // checks
  logic [19:0] ast_cnt_r;
  logic [19:0] ast_lcnt_r;
  always_ff @(posedge aclk)
  begin
    ast_cnt_r  <= (s_r.state == ST_ALTSET || s_r.state == ST_VSSET) ? ast_cnt_r + 20'h1 : 20'h0;
    ast_lcnt_r <= (s_r.ls_s2 && !s_r.ls_prev) ? 20'h1 : ast_lcnt_r + 20'h1;
  end

  sequence seq_ramp_done;
    s_r.state == ST_RAMP && clk_ramped;
  endsequence
  sequence seq_alt_exit;
    s_r.state == ST_LOWPWR && lp_exit && s_r.alt_used;
  endsequence

  AST_ALT_AFTER_RAMP: assert property (@(posedge aclk) disable iff (!aresetn) // [R03]
    seq_ramp_done |=> core_cmd_stb && core_voltage_id == $past(s_r.alt_vid) && clk_ramp_req)
    else $error("alternate id not issued after clock ramp");
  AST_RESTORE_FIRST: assert property (@(posedge aclk) disable iff (!aresetn) // [R02]
    seq_alt_exit |=> core_cmd_stb && core_voltage_id == s_r.op_vid ##1 !exec_resume)
    else $error("operating id not restored on exit");
  AST_ALT_SETTLE: assert property (@(posedge aclk) disable iff (!aresetn) // [R15]
    exec_resume && $past(s_r.state) == ST_ALTSET
      |-> ast_cnt_r == 20'(settle_us(s_r.alt_set)) * 20'(CYC_PER_US))
    else $error("resume before alternate settle time");
  AST_VS_SETTLE: assert property (@(posedge aclk) disable iff (!aresetn) // [R08]
    fid_change_go && $past(s_r.state) == ST_VSSET
      |-> ast_cnt_r == 20'(settle_us(s_r.vs_set)) * 20'(CYC_PER_US))
    else $error("frequency change before voltage settle time");
  AST_NO_DOWN_WAIT: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
    s_r.state == ST_IDLE && !lp_enter && vid_req && vid_req_value >= s_r.core_vid
      |=> fid_change_go && core_cmd_stb)
    else $error("wait inserted after lowering command");
  AST_NB_CHANGE: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
    $changed(northbridge_voltage_id) |-> nb_cmd_stb)
    else $error("northbridge id changed without command");
  AST_RX_1US: assert property (@(posedge aclk) disable iff (!aresetn) // [R06]
    $rose(link_rx_en) |-> ast_lcnt_r == 20'(CYC_PER_US) + 20'h2)
    else $error("receiver not enabled at one microsecond");
  AST_CTL_HOLD: assert property (@(posedge aclk) disable iff (!aresetn) // [R05]
    $rose(link_control_signal) && s_r.tri_en && s_r.rxls > `VTT_RXLS_ONE
      |-> ast_lcnt_r > 20'(s_r.lnk_dly) * 20'(CYC_PER_US))
    else $error("link control asserted before delay");
  AST_MAX_PS: assert property (@(posedge aclk) // [R12]
    $rose(aresetn) |-> s_r.max_ps == top_ps($past(perf_state_enable)))
    else $error("max performance index not from enables");

endmodule

`default_nettype wire

// ### vtt_defs.svh
// Purpose: offsets, field positions, reset values and timing figures of the
//          voltage transition timing block
// Assumes: byte addresses on a 32-bit register bus
// Notes:   definitions only
`ifndef VTT_DEFS_SVH
`define VTT_DEFS_SVH

// ==========================================================================
// register offsets
`define VTT_OFS_CTL1          8'hD8
`define VTT_OFS_CTL2          8'hDC
`define VTT_OFS_SEQ           8'hE0

// ==========================================================================
// control one fields
`define VTT_LNK_DLY_MSB       27
`define VTT_LNK_DLY_LSB       24
`define VTT_ALT_SET_MSB       6
`define VTT_ALT_SET_LSB       4
`define VTT_VS_SET_MSB        2
`define VTT_VS_SET_LSB        0
`define VTT_LNK_DLY_RST       4'h0
`define VTT_ALT_SET_RST       3'h7
`define VTT_VS_SET_RST        3'h7

// ==========================================================================
// control two fields
`define VTT_NB_VID_MSB        18
`define VTT_NB_VID_LSB        12
`define VTT_MAX_PS_MSB        10
`define VTT_MAX_PS_LSB        8
`define VTT_ALT_VID_MSB       6
`define VTT_ALT_VID_LSB       0

// ==========================================================================
// sequence control and status fields
`define VTT_SEQ_ALT_EN        0
`define VTT_SEQ_TRI_EN        1
`define VTT_SEQ_RXLS_MSB      3
`define VTT_SEQ_RXLS_LSB      2
`define VTT_SEQ_ST_MSB        13
`define VTT_SEQ_ST_LSB        8
`define VTT_SEQ_VID_MSB       22
`define VTT_SEQ_VID_LSB       16
`define VTT_RXLS_ONE          2'h1

// ==========================================================================
// bus answers
`define VTT_RESP_OKAY         2'h0
`define VTT_RESP_SLVERR       2'h2

// ==========================================================================
// timing
`define VTT_CLK_NS            5
`define VTT_US_NS             1000
`define VTT_RX_EN_US          1
`define VTT_SETTLE_US0        10'h00A
`define VTT_SETTLE_US1        10'h014
`define VTT_SETTLE_US2        10'h01E
`define VTT_SETTLE_US3        10'h028
`define VTT_SETTLE_US4        10'h03C
`define VTT_SETTLE_US5        10'h064
`define VTT_SETTLE_US6        10'h0C8
`define VTT_SETTLE_US7        10'h1F4

`endif

// ### vtt_pkg.sv
// Purpose: types of the voltage transition timing block
// Assumes: nothing beyond the defines header
// Notes:   one-hot sequencer codes
package vtt_pkg;

  typedef enum logic [5:0]
  {
    ST_IDLE   = 6'h01,
    ST_RAMP   = 6'h02,
    ST_LOWPWR = 6'h04,
    ST_ALTSET = 6'h08,
    ST_VSSET  = 6'h10,
    ST_SPARE  = 6'h20
  } vtt_state_t;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              aw_held;
    logic              w_held;
    logic [7:0]        awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [3:0]        lnk_dly;
    logic [2:0]        alt_set;
    logic [2:0]        vs_set;
    logic [6:0]        nb_vid;
    logic [2:0]        max_ps;
    logic [6:0]        alt_vid;
    logic              alt_en;
    logic              tri_en;
    logic [1:0]        rxls;
    vtt_state_t        state;
    logic              alt_used;
    logic [6:0]        core_vid;
    logic [6:0]        op_vid;
    logic              core_cmd;
    logic              nb_cmd;
    logic              ramp_req;
    logic              resume;
    logic              fid_go;
    logic [9:0]        set_us;
    logic [7:0]        set_pre;
    logic              ls_s1;
    logic              ls_s2;
    logic              ls_prev;
    logic              lnk_run;
    logic [4:0]        lnk_us;
    logic [7:0]        lnk_pre;
    logic              rx_en;
    logic              ctl_en;
  } vtt_state_reg_t;

endpackage

// ### vtt_vreg_model.sv
// Purpose: regulator model taking serial voltage commands
// Assumes: a strobe qualifies the id present in the same cycle
// Notes:   counts commands per plane
`timescale 1ns/100ps
`default_nettype none
module vtt_vreg_model
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       core_cmd_stb,
  input  wire logic       nb_cmd_stb,
  input  wire logic [6:0] core_voltage_id,
  input  wire logic [6:0] northbridge_voltage_id,
  output var  logic [6:0] core_level,
  output var  logic [6:0] nb_level,
  output var  int         core_cmds,
  output var  int         nb_cmds
);
  // ====
  // plane levels move only on a command
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_cmds <= 0;
      nb_cmds   <= 0;
    end
    else
    begin
      if (core_cmd_stb)
      begin
        core_level <= core_voltage_id;
        core_cmds  <= core_cmds + 1;
      end
      if (nb_cmd_stb)
      begin
        nb_level <= northbridge_voltage_id;
        nb_cmds  <= nb_cmds + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb_top.sv
// Purpose: self-checking bench of the voltage transition timing block
// Assumes: default id parameters of the design
// Notes:   bready and rready stay high
`include "vtt_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, lp_enter, lp_exit, clk_ramped, vid_req, link_stop_n;
  logic        core_cmd_stb, nb_cmd_stb, clk_ramp_req, exec_resume, fid_change_go;
  logic        link_rx_en, link_control_signal;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, perf_state_enable;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [6:0]  vid_req_value, core_voltage_id, northbridge_voltage_id, core_level, nb_level;
  logic [6:0]  alt, nb;
  int          core_cmds, nb_cmds, error_cnt, checks, n, m;

  vtt_top u_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .lp_enter, .lp_exit, .clk_ramped, .vid_req,
    .vid_req_value, .perf_state_enable, .link_stop_n, .core_voltage_id,
    .northbridge_voltage_id, .core_cmd_stb, .nb_cmd_stb, .clk_ramp_req, .exec_resume,
    .fid_change_go, .link_rx_en, .link_control_signal);
  vtt_vreg_model u_vreg (.aclk, .aresetn, .core_cmd_stb, .nb_cmd_stb, .core_voltage_id,
    .northbridge_voltage_id, .core_level, .nb_level, .core_cmds, .nb_cmds);

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ====
  // checking and closing
  task automatic close_out;
    $display("errors=%0d checks=%0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h range=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic tmo;
    chk(32'h0, 32'h1);
    close_out();
  endtask

  function automatic logic sig(input int i);
    case (i)
      0: return core_cmd_stb;
      1: return exec_resume;
      2: return fid_change_go;
      3: return clk_ramp_req;
      4: return link_rx_en;
      default: return link_control_signal;
    endcase
  endfunction

  function automatic logic [2:0] hi_bit(input logic [7:0] e);
    hi_bit = 3'h0;
    for (int k = 0; k < 8; k++)
      if (e[k])
        hi_bit = k[2:0];
  endfunction

  // ====
  // drivers
  task automatic wait_for(input int i, output int c);
    c = 0;
    do
    begin
      @(posedge aclk);
      c++;
    end
    while (sig(i) !== 1'b1 && c < 6000);
    if (sig(i) !== 1'b1)
      tmo();
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int c;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    c = 0;
    do
    begin
      @(posedge aclk);
      c++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && c < 100);
    r = s_axi_bresp;
    if (c >= 100)
      tmo();
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int c;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    c = 0;
    do
    begin
      @(posedge aclk);
      c++;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && c < 100);
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (c >= 100)
      tmo();
  endtask

  task automatic pulse(input int i);
    if (i == 0)
      lp_enter <= 1'b1;
    else if (i == 1)
      lp_exit <= 1'b1;
    else
      vid_req <= 1'b1;
    @(posedge aclk);
    lp_enter <= 1'b0;
    lp_exit  <= 1'b0;
    vid_req  <= 1'b0;
  endtask

  task automatic link_cycle;
    link_stop_n <= 1'b0;
    repeat (10) @(posedge aclk);
    chk({link_rx_en, link_control_signal}, 32'h0);
    link_stop_n <= 1'b1;
  endtask

  // ====
  // main sequence
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, lp_enter, lp_exit} = '0;
    {clk_ramped, vid_req, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_bready, s_axi_rready, link_stop_n, s_axi_wstrb} = 7'h7F;
    vid_req_value = 7'h30;
    error_cnt = 0;
    checks = 0;
    n = $urandom(32'hB6F1);
    perf_state_enable = 8'($urandom_range(255, 1));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(`VTT_OFS_CTL1, rd, rs);
    chk(rd, 32'h0000_0077);
    axr(`VTT_OFS_CTL2, rd, rs);
    chk(rd, {13'h0, 7'h40, 1'b0, hi_bit(perf_state_enable), 1'b0, 7'h40});
    axr(8'h10, rd, rs);
    chk(rd, 32'h0);
    chk(rs, `VTT_RESP_SLVERR);
    axw(8'h10, 32'hFFFF_FFFF, rs);
    chk(rs, `VTT_RESP_SLVERR);
    axw(`VTT_OFS_CTL1, 32'h0300_0001, rs);
    axr(`VTT_OFS_CTL1, rd, rs);
    chk(rd, 32'h0300_0001);
    // alternate id kept inside the regulator limits
    nb  = 7'($urandom_range(63, 32));
    alt = 7'($urandom_range(80, 56));
    m   = nb_cmds;
    axw(`VTT_OFS_CTL2, {13'h0, nb, 1'b0, 3'h2, 1'b0, alt}, rs);
    axw(`VTT_OFS_CTL2, {13'h0, nb, 1'b0, 3'h2, 1'b0, alt}, rs);
    chk(32'(nb_cmds - m), 32'h1);
    chk(nb_level, nb);
    vid_req_value <= 7'h30 - 7'($urandom_range(15, 1));
    pulse(2);
    wait_for(0, n);
    wait_for(2, n);
    chk(n, `VTT_SETTLE_US1 * 200);
    vid_req_value <= 7'h3A;
    pulse(2);
    wait_for(0, n);
    chk(fid_change_go, 32'h1);
    axw(`VTT_OFS_SEQ, 32'h1, rs);
    chk(core_level, 7'h3A);
    m = core_cmds;
    pulse(0);
    wait_for(3, n);
    repeat (4) @(posedge aclk);
    chk(32'(core_cmds - m), 32'h0);
    clk_ramped <= 1'b1;
    wait_for(0, n);
    @(posedge aclk);
    chk(core_level, alt);
    clk_ramped <= 1'b0;
    pulse(1);
    wait_for(0, n);
    wait_for(1, n);
    chk(n, `VTT_SETTLE_US0 * 200);
    chk(clk_ramp_req, 32'h0);
    chk(core_level, 7'h3A);
    axw(`VTT_OFS_SEQ, 32'hB, rs);
    link_cycle();
    wait_for(4, n);
    wait_for(5, m);
    chk_rng(n, 200, 210);
    chk_rng(n + m, 600, 615);
    axw(`VTT_OFS_SEQ, 32'h3, rs);
    link_cycle();
    wait_for(5, m);
    chk_rng(m, 1, 10);
    close_out();
  end
endmodule
`default_nettype wire
